// [rtl/led_pkg.sv]
/*
  Shared constants and carriers for the LED driver's two-wire register slave.
  Assumes a single 40 MHz clock domain; bus pins are synchronised inside the slave.
*/
package led_pkg;

  // ******************************************************************
  // Bus identity and register map
  // ******************************************************************
  localparam logic [6:0] SLAVE_ADDR = 7'h66;
  localparam logic [7:0] OFF_PAIR_A = 8'h00;
  localparam logic [7:0] OFF_PAIR_B = 8'h01;
  localparam logic [7:0] OFF_PAIR_C = 8'h02;
  localparam logic [7:0] OFF_CHANNEL_ON_OFF = 8'h03;
  localparam int NUM_REGS = 4;
  localparam int CODE_MSB = 5;
  localparam logic [5:0] LEVEL_RESET = 6'h00;
  localparam logic [5:0] ON_OFF_RESET = 6'h00;

  // ******************************************************************
  // Channel bit positions in the on/off register
  // ******************************************************************
  localparam int BIT_A_FIRST = 0;
  localparam int BIT_A_SECOND = 1;
  localparam int BIT_B_FIRST = 2;
  localparam int BIT_B_SECOND = 3;
  localparam int BIT_C_FIRST = 4;
  localparam int BIT_C_SECOND = 5;

  // ******************************************************************
  // Timing: fastest supported bus rate
  // ******************************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int BUS_MAX_BPS = 400_000;
  localparam int CYCLES_PER_BIT = CLK_HZ / BUS_MAX_BPS;

  // Current per step is 0.5 mA; level index n gives (n+1) half-milliamps
  typedef struct packed {
    logic [6:0] pair_a_half_ma;
    logic [6:0] pair_b_half_ma;
    logic [6:0] pair_c_half_ma;
  } current_s;

  typedef struct packed {
    logic channel_c_second;
    logic channel_c_first;
    logic channel_b_second;
    logic channel_b_first;
    logic channel_a_second;
    logic channel_a_first;
  } channels_s;

endpackage : led_pkg

// [rtl/led_reg_file.sv]
/*
  Holds the three pair-current codes and the channel on/off bits.
  Assumes write and read requests come from the serial slave on clk.
*/
`timescale 1ns/1ps
module led_reg_file
  import led_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic [5:0] level_a,
  output logic [5:0] level_b,
  output logic [5:0] level_c,
  output logic [5:0] on_off,
  output logic on_off_written
);

  typedef struct packed {
    logic [5:0] a;
    logic [5:0] b;
    logic [5:0] c;
    logic [5:0] en;
    logic [7:0] rd;
    logic wen;
  } regs_s;

  regs_s r;
  regs_s next_r;

  always_comb begin
    next_r = r;
    next_r.wen = 1'b0;
    if (wr) begin
      case (addr)
        OFF_PAIR_A: next_r.a = wdata[5:0];
        OFF_PAIR_B: next_r.b = wdata[5:0];
        OFF_PAIR_C: next_r.c = wdata[5:0];
        OFF_CHANNEL_ON_OFF: begin
          next_r.en = wdata[5:0];
          next_r.wen = 1'b1;
        end
        default: ;
      endcase
    end
    case (addr)
      OFF_PAIR_A: next_r.rd = {2'h0, r.a};
      OFF_PAIR_B: next_r.rd = {2'h0, r.b};
      OFF_PAIR_C: next_r.rd = {2'h0, r.c};
      OFF_CHANNEL_ON_OFF: next_r.rd = {2'h0, r.en};
      default: next_r.rd = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '{a: LEVEL_RESET, b: LEVEL_RESET, c: LEVEL_RESET,
             en: ON_OFF_RESET, rd: 8'h00, wen: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign rdata = r.rd;
  assign level_a = r.a;
  assign level_b = r.b;
  assign level_c = r.c;
  assign on_off = r.en;
  assign on_off_written = r.wen;

endmodule : led_reg_file

// [rtl/led_current_i2c_regs.sv]
/*
  Two-wire serial slave with register file for a six-channel LED driver.
  Assumes scl, sda and the enable pin arrive asynchronously; the sda pin
  is open drain, resolved outside from sda_out and sda_oe.
*/
`timescale 1ns/1ps

// How it works
// - Channel current is (code+1) half-milliamps; top two bits ignored.
// - Answer only slave address 1100110; stay passive otherwise.
// - Slave address arrives most significant bit first.
// - Bus rates up to 400 kbit/s are handled by oversampling.
// - Write: address, register address, data byte, stored in register.
// - Direction bit one means read, zero means write.
// - Read uses repeated start after register address; return that byte.
// - Acknowledge slave address, register address and each written byte.
// - Device is slave only and never starts a transfer.
// - Four registers at addresses 0 to 3: pairs A, B, C, on/off.
// - On/off bits 0 to 5 switch A1, A2, B1, B2, C1, C2.
// - Each on/off write restarts pump mode selection from 1x.
// - Enable pin low: shutdown, all off; rising: currents at zero (here codes are kept and return at the next on/off write).
module led_current_i2c_regs
  import led_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic enable_pin,
  output led_pkg::current_s current,
  output led_pkg::channels_s channels,
  output logic pump_restart
);
  import led_pkg::*;

  // ******************************************************************
  // Slave states
  // ******************************************************************
  typedef enum logic [2:0] {
    IDLE, ADDR, ACK, REG, DATA, TX, TXACK
  } st_e;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] en_s;
    logic scl_d;
    logic sda_d;
    logic en_d;
    st_e st;
    st_e after_ack;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] addr;
    logic wr;
    logic drive_low;
    logic live;
    current_s cur;
    channels_s ch;
    logic restart;
  } state_s;

  state_s s;
  state_s next_s;
  logic [7:0] rdata;
  logic [5:0] lv_a;
  logic [5:0] lv_b;
  logic [5:0] lv_c;
  logic [5:0] on_off;
  logic on_off_written;

  function automatic logic [6:0] half_ma(input logic [5:0] code);
    half_ma = {1'b0, code} + 7'h01;
  endfunction : half_ma

  led_reg_file regs (
    .clk(clk),
    .nrst(nrst),
    .wr(s.wr),
    .addr(s.addr),
    .wdata(s.sh),
    .rdata(rdata),
    .level_a(lv_a),
    .level_b(lv_b),
    .level_c(lv_c),
    .on_off(on_off),
    .on_off_written(on_off_written)
  );

  // ******************************************************************
  // Bus engine
  // ******************************************************************
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    // Sampled at 40 MHz, 100 clocks per bit at 400 kbit/s
    scl_rise = s.scl_s[1] & ~s.scl_d;
    scl_fall = ~s.scl_s[1] & s.scl_d;
    start_c = s.scl_s[1] & s.scl_d & s.sda_d & ~s.sda_s[1];
    stop_c = s.scl_s[1] & s.scl_d & ~s.sda_d & s.sda_s[1];
    next_s = s;
    next_s.scl_s = {s.scl_s[0], scl};
    next_s.sda_s = {s.sda_s[0], sda_in};
    next_s.en_s = {s.en_s[0], enable_pin};
    next_s.scl_d = s.scl_s[1];
    next_s.sda_d = s.sda_s[1];
    next_s.en_d = s.en_s[1];
    next_s.wr = 1'b0;
    if (start_c) begin
      // Also a repeated start: the register address is kept
      next_s.st = ADDR;
      next_s.cnt = 4'h0;
      next_s.drive_low = 1'b0;
    end else if (stop_c) begin
      next_s.st = IDLE;
      next_s.drive_low = 1'b0;
    end else begin
      case (s.st)
        IDLE: next_s.drive_low = 1'b0;
        ADDR, REG, DATA: begin
          if (scl_rise) begin
            next_s.sh = {s.sh[6:0], s.sda_s[1]};
            next_s.cnt = s.cnt + 4'h1;
          end
          // Decode after eight bits; the fall that ends a start is skipped
          if (scl_fall && s.cnt == 4'h8) begin
            if (s.st == ADDR) begin
              if (s.sh[7:1] == SLAVE_ADDR) begin
                next_s.drive_low = 1'b1;
                next_s.st = ACK;
                next_s.after_ack = s.sh[0] ? TX : REG;
              end else begin
                next_s.st = IDLE;
              end
            end else begin
              next_s.drive_low = 1'b1;
              next_s.st = ACK;
              if (s.st == REG) begin
                next_s.addr = s.sh;
              end else begin
                next_s.wr = 1'b1;
              end
              next_s.after_ack = DATA;
            end
          end
        end
        ACK: begin
          if (scl_fall) begin
            next_s.st = s.after_ack;
            next_s.cnt = 4'h0;
            if (s.after_ack == TX) begin
              next_s.sh = rdata;
              next_s.drive_low = ~rdata[7];
            end else begin
              next_s.drive_low = 1'b0;
            end
          end
        end
        TX: begin
          if (scl_fall) begin
            next_s.cnt = s.cnt + 4'h1;
            if (s.cnt == 4'h7) begin
              next_s.drive_low = 1'b0;
              next_s.st = TXACK;
            end else begin
              next_s.sh = {s.sh[6:0], 1'b0};
              next_s.drive_low = ~s.sh[6];
            end
          end
        end
        TXACK: begin
          if (scl_rise) begin
            // Not-acknowledge ends the read; line stays released
            next_s.st = s.sda_s[1] ? IDLE : ACK;
            next_s.after_ack = TX;
          end
        end
        default: next_s.st = IDLE;
      endcase
    end
    // ****************************************************************
    // Channel outputs
    // ****************************************************************
    next_s.restart = on_off_written | (s.en_s[1] & ~s.en_d);
    if (!s.en_s[1]) begin
      next_s.live = 1'b0;
    end else if (on_off_written) begin
      next_s.live = 1'b1;
    end
    next_s.ch = s.live ? channels_s'(on_off) : '0;
    next_s.cur.pair_a_half_ma = s.live ? half_ma(lv_a) : 7'h00;
    next_s.cur.pair_b_half_ma = s.live ? half_ma(lv_b) : 7'h00;
    next_s.cur.pair_c_half_ma = s.live ? half_ma(lv_c) : 7'h00;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '{scl_s: 2'h3, sda_s: 2'h3, en_s: 2'h0, scl_d: 1'b1,
             sda_d: 1'b1, en_d: 1'b0, st: IDLE, after_ack: IDLE,
             cnt: 4'h0, sh: 8'h00, addr: 8'h00, wr: 1'b0,
             drive_low: 1'b0, live: 1'b0, cur: '0, ch: '0,
             restart: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = s.drive_low;
  assign current = s.cur;
  assign channels = s.ch;
  assign pump_restart = s.restart;

endmodule : led_current_i2c_regs

// [test/led_regs_monitor.sv]
/* Port checker for the LED register slave.
   Bound to the top module by the bench; one clock domain. */
`timescale 1ns/1ps
module led_regs_monitor
  import led_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic enable_pin,
  input wire led_pkg::current_s current,
  input wire led_pkg::channels_s channels,
  input wire logic pump_restart
);
  import led_pkg::*;
  // ****
  // Port rules
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence en_low_s;
    !enable_pin [*4];
  endsequence
  shutdown_off_a:
    assert property (en_low_s |=> channels == 6'h00 && current == 21'h0)
    else $error("outputs live while disabled");
  lit_needs_en_a:
    assert property ((channels != 6'h00 || current != 21'h0)
      |-> $past(enable_pin, 4)) else $error("outputs lit without enable");
  level_range_a:
    assert property (current.pair_a_half_ma <= 7'h40 &&
      current.pair_b_half_ma <= 7'h40 && current.pair_c_half_ma <= 7'h40)
    else $error("current above top step");
  restart_pulse_a:
    assert property (pump_restart |=> !pump_restart)
    else $error("restart longer than one cycle");
  restart_enabled_a:
    assert property (pump_restart |-> $past(enable_pin, 2))
    else $error("restart while disabled");
  oe_scl_low_a:
    assert property ($changed(sda_oe) |-> !scl)
    else $error("data line moved while clock high");
  open_drain_a:
    assert property (sda_out == 1'b0) else $error("data pin driven high");
  reset_clears_a:
    assert property (disable iff (1'b0) !nrst |=> !sda_oe &&
      current == 21'h0 && channels == 6'h00 && !pump_restart)
    else $error("outputs not cleared by reset");
endmodule : led_regs_monitor

// [test/led_bus_master.sv]
/* Two-wire bus master model, 400 kbit/s at a 40 MHz clock.
   Expects the resolved data line on sda; only ever pulls it low. */
`timescale 1ns/1ps
module led_bus_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // ****
  // Bit and frame tasks
  // ****
  localparam int Q = 25;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick();
    repeat (Q) @(posedge clk);
  endtask : tick
  task automatic put_bit(input logic b, output logic r);
    sda_pull <= !b;
    tick();
    scl <= 1'b1;
    tick();
    r = sda;
    tick();
    scl <= 1'b0;
    tick();
  endtask : put_bit
  task automatic start();
    sda_pull <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_pull <= 1'b1;
    tick();
    scl <= 1'b0;
    tick();
  endtask : start
  task automatic stop();
    sda_pull <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_pull <= 1'b0;
    tick();
  endtask : stop
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(v[i], r);
    put_bit(1'b1, r);
    ack = !r;
  endtask : put_byte
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra,
      input logic [7:0] d, output logic [2:0] ack);
    start();
    put_byte({dev, 1'b0}, ack[2]);
    put_byte(ra, ack[1]);
    put_byte(d, ack[0]);
    stop();
  endtask : write_reg
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ra,
      output logic [7:0] d, output logic [2:0] ack);
    logic r;
    start();
    put_byte({dev, 1'b0}, ack[2]);
    put_byte(ra, ack[1]);
    start();
    put_byte({dev, 1'b1}, ack[0]);
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(1'b1, r);
    stop();
  endtask : read_reg
endmodule : led_bus_master

// [test/led_current_i2c_regs_test.sv]
/* Top bench for the LED register slave with master model.
   Needs the design, the master model and the port checker. */
`timescale 1ns/1ps
bind led_current_i2c_regs led_regs_monitor u_mon (.clk(clk), .nrst(nrst),
  .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe), .enable_pin(enable_pin),
  .current(current), .channels(channels), .pump_restart(pump_restart));
module led_current_i2c_regs_test;
  import led_pkg::*;
  // ****
  // Bench
  // ****
  logic clk, nrst, enable_pin, scl, sda_pull, sda_out, sda_oe, sda;
  logic pump_restart;
  current_s current;
  channels_s channels;
  logic [2:0] ack;
  logic [7:0] rd;
  logic [6:0] bad [2] = '{7'h67, 7'h33};
  int n_errors = 0;
  int num_checks = 0;
  int n_restart = 0;
  int base;
  assign sda = !(sda_pull || (sda_oe && !sda_out));
  led_current_i2c_regs u_dut (.clk(clk), .nrst(nrst), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .enable_pin(enable_pin), .current(current), .channels(channels),
    .pump_restart(pump_restart));
  led_bus_master u_master (.clk(clk), .sda(sda), .scl(scl),
    .sda_pull(sda_pull));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  // Counts pump restart pulses seen at the port
  always @(posedge clk) begin
    if (pump_restart === 1'b1) n_restart <= n_restart + 1;
  end
  task automatic check(input logic [20:0] seen, input logic [20:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    u_master.write_reg(SLAVE_ADDR, ra, d, ack);
    check(ack, 3'h7);
  endtask : wr
  task automatic rd_chk(input logic [7:0] ra, input logic [7:0] exp);
    u_master.read_reg(SLAVE_ADDR, ra, rd, ack);
    check(ack, 3'h7);
    check(rd, exp);
  endtask : rd_chk
  initial begin
    nrst = 1'b0;
    enable_pin = 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
    check(channels, 6'h00);
    enable_pin <= 1'b1;
    wr(OFF_PAIR_A, 8'hFF);
    wr(OFF_PAIR_B, 8'h00);
    wr(OFF_PAIR_C, 8'hE8);
    check(current, 21'h0);
    rd_chk(OFF_PAIR_A, 8'h3F);
    rd_chk(OFF_PAIR_B, 8'h00);
    rd_chk(OFF_PAIR_C, 8'h28);
    wr(OFF_CHANNEL_ON_OFF, 8'hFF);
    check(current, {7'h40, 7'h01, 7'h29});
    check(channels, 6'h3F);
    for (int i = 0; i < 6; i++) begin
      base = n_restart;
      wr(OFF_CHANNEL_ON_OFF, 8'h01 << i);
      check(channels, 6'h01 << i);
      check(n_restart - base, 1);
    end
    for (int i = 0; i < 2; i++) begin
      wr(OFF_CHANNEL_ON_OFF, 8'h00);
      check(channels, 6'h00);
      check(current, {7'h40, 7'h01, 7'h29});
      wr(OFF_CHANNEL_ON_OFF, 8'h3F);
      check(channels, 6'h3F);
    end
    foreach (bad[k]) begin
      u_master.write_reg(bad[k], OFF_PAIR_A, 8'h11, ack);
      check(ack, 3'h0);
    end
    wr(8'h04, 8'h15);
    rd_chk(8'h04, 8'h00);
    rd_chk(OFF_PAIR_A, 8'h3F);
    enable_pin <= 1'b0;
    repeat (10) @(posedge clk);
    check(channels, 6'h00);
    check(current, 21'h0);
    base = n_restart;
    enable_pin <= 1'b1;
    repeat (10) @(posedge clk);
    check(current, 21'h0);
    check(n_restart - base, 1);
    rd_chk(OFF_PAIR_C, 8'h28);
    report_and_stop();
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule : led_current_i2c_regs_test
